/* File: hw/ddr3_pwr_core.sv */
/*
 * DDR3 command decode and power-state core: bank tracking, mode register
 * capture, burst timing with the DLL-off read shift, and the CKE driven
 * moves between idle, active, power-down and self refresh.
 * Assumes the controller keeps its own timing (CKE hold, exit times,
 * frequency changes) and that all pins but the asynchronous reset_n are synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "ddr3_pwr_regs.svh"

module ddr3_pwr_core (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Command pins from the controller.
	input wire logic cke,
	input wire ddr3_pwr_pkg::cmd_pins_type cmd_pins,
	input wire logic [2:0] ba,
	input wire logic [13:0] addr,
	input wire logic odt,
	// Device state for the rest of the chip.
	output ddr3_pwr_pkg::pwr_state_type pwr_state,
	output logic [7:0] bank_open,
	output logic burst_busy,
	output logic read_strobe,
	output logic write_window,
	output logic odt_active,
	output logic dll_disabled,
	output logic lat_error
);

	// Registered state and its next value.
	ddr3_pwr_pkg::core_state_type st_reg;
	ddr3_pwr_pkg::core_state_type st_next;
	// Command decoded at this edge.
	ddr3_pwr_pkg::cmd_type cmd;
	// Banks that stay open once a pending auto-precharge lands.
	logic [7:0] banks_after;
	// A burst is still counting down, through its latency or its data.
	logic busy;

	// Maps the four strobes to a command; ODT plays no part here.
	function automatic ddr3_pwr_pkg::cmd_type decode(
		input ddr3_pwr_pkg::cmd_pins_type p);
		logic [2:0] rcw;
		rcw = {p.ras_n, p.cas_n, p.we_n};
		if (p.cs_n) begin
			decode = ddr3_pwr_pkg::CMD_DES;
		end else begin
			case (rcw)
				3'h0: decode = ddr3_pwr_pkg::CMD_MRS;
				3'h1: decode = ddr3_pwr_pkg::CMD_REF;
				3'h2: decode = ddr3_pwr_pkg::CMD_PRE;
				3'h3: decode = ddr3_pwr_pkg::CMD_ACT;
				3'h4: decode = ddr3_pwr_pkg::CMD_WR;
				3'h5: decode = ddr3_pwr_pkg::CMD_RD;
				3'h6: decode = ddr3_pwr_pkg::CMD_ZQ;
				default: decode = ddr3_pwr_pkg::CMD_NOP;
			endcase
		end
	endfunction

	// CAS latency in cycles from mode register 0.
	function automatic logic [5:0] cas_lat(input logic [13:0] m0);
		cas_lat = {3'h0, m0[`MR0_CL_MSB:`MR0_CL_LSB]} + `CL_BASE;
	endfunction

	// CAS write latency in cycles from mode register 2.
	function automatic logic [5:0] cas_wr_lat(input logic [13:0] m2);
		cas_wr_lat = {3'h0, m2[`MR2_CWL_MSB:`MR2_CWL_LSB]} + `CWL_BASE;
	endfunction

	// Additive latency: zero, CL-1 or CL-2; the reserved code gives zero.
	function automatic logic [5:0] add_lat(input logic [13:0] m0,
		input logic [13:0] m1);
		logic [5:0] cl;
		cl = cas_lat(m0);
		case (m1[`MR1_AL_MSB:`MR1_AL_LSB])
			2'h1: add_lat = cl - 6'h01;
			2'h2: add_lat = cl - 6'h02;
			default: add_lat = 6'h00;
		endcase
	endfunction

	// Read latency; with the DLL off the strobe starts a cycle early.
	function automatic logic [5:0] read_lat(input logic [13:0] m0,
		input logic [13:0] m1);
		logic [5:0] rl;
		rl = add_lat(m0, m1) + cas_lat(m0);
		if (m1[`MR1_DLL_OFF_BIT]) begin
			rl = rl - 6'h01;
		end
		read_lat = rl;
	endfunction

	// Any termination enabled in mode registers 1 or 2.
	function automatic logic rtt_on(input logic [13:0] m1,
		input logic [13:0] m2);
		rtt_on = m1[`MR1_RTT_B0] | m1[`MR1_RTT_B1] | m1[`MR1_RTT_B2] |
			(|m2[`MR2_RTTWR_MSB:`MR2_RTTWR_LSB]);
	endfunction

	// Next-state logic: burst progress first, then CKE and command.
	always_comb begin
		st_next = st_reg;
		cmd = decode(cmd_pins);
		busy = (st_reg.burst_cnt != 6'h00);
		st_next.cke_prev = cke;
		if (busy) begin
			st_next.burst_cnt = st_reg.burst_cnt - 6'h01;
			// Auto-precharge closes the bank when the burst ends.
			if (st_reg.burst_cnt == 6'h01 && st_reg.burst_ap) begin
				st_next.bank_open[st_reg.burst_bank] = 1'b0;
			end
		end
		banks_after = st_next.bank_open;
		if (busy && st_reg.burst_ap) begin
			banks_after[st_reg.burst_bank] = 1'b0;
		end
		case (st_reg.pwr)
			ddr3_pwr_pkg::PWR_SELF_REF: begin
				if (cke) begin
					st_next.pwr = ddr3_pwr_pkg::PWR_IDLE;
				end
			end
			ddr3_pwr_pkg::PWR_ACT_PD, ddr3_pwr_pkg::PWR_PRE_PD: begin
				if (cke) begin
					st_next.pwr = (|st_next.bank_open) ?
						ddr3_pwr_pkg::PWR_ACTIVE : ddr3_pwr_pkg::PWR_IDLE;
				end
			end
			ddr3_pwr_pkg::PWR_IDLE, ddr3_pwr_pkg::PWR_ACTIVE: begin
				if (st_reg.cke_prev && !cke) begin
					if (cmd == ddr3_pwr_pkg::CMD_REF &&
						st_reg.pwr == ddr3_pwr_pkg::PWR_IDLE && !busy) begin
						st_next.pwr = ddr3_pwr_pkg::PWR_SELF_REF;
					end else if (cmd == ddr3_pwr_pkg::CMD_NOP ||
						cmd == ddr3_pwr_pkg::CMD_DES) begin
						st_next.pwr = (|banks_after) ?
							ddr3_pwr_pkg::PWR_ACT_PD :
							ddr3_pwr_pkg::PWR_PRE_PD;
					end
				end else if (st_reg.cke_prev && cke) begin
					case (cmd)
						ddr3_pwr_pkg::CMD_MRS: begin
							if (st_reg.pwr == ddr3_pwr_pkg::PWR_IDLE) begin
								case (ba)
									3'h0: st_next.mr0 = addr;
									3'h1: st_next.mr1 = addr;
									3'h2: st_next.mr2 = addr;
									default: st_next.mr0 = st_reg.mr0;
								endcase
							end
						end
						ddr3_pwr_pkg::CMD_ACT: begin
							st_next.bank_open[ba] = 1'b1;
						end
						ddr3_pwr_pkg::CMD_PRE: begin
							if (addr[`ADDR_AP_BIT]) begin
								st_next.bank_open = 8'h00;
							end else begin
								st_next.bank_open[ba] = 1'b0;
							end
						end
						ddr3_pwr_pkg::CMD_RD, ddr3_pwr_pkg::CMD_WR: begin
							// no new burst cuts a running one
							if (!busy && st_reg.bank_open[ba]) begin
								// A12 chooses chop on the fly
								if (st_reg.mr0[`MR0_BL_MSB:`MR0_BL_LSB] ==
									`BL_OTF) begin
									st_next.beats = addr[`ADDR_BC_BIT] ?
										`BEATS_BL8 : `BEATS_BC4;
								end else if (st_reg.mr0[`MR0_BL_MSB:
									`MR0_BL_LSB] == `BL_FIXED4) begin
									st_next.beats = `BEATS_BC4;
								end else begin
									st_next.beats = `BEATS_BL8;
								end
								st_next.burst_rd = (cmd == ddr3_pwr_pkg::CMD_RD);
								st_next.burst_ap = addr[`ADDR_AP_BIT];
								st_next.burst_bank = ba;
								st_next.burst_cnt = st_next.beats + (st_next.burst_rd ?
									read_lat(st_reg.mr0, st_reg.mr1) :
									add_lat(st_reg.mr0, st_reg.mr1) +
									cas_wr_lat(st_reg.mr2));
							end
						end
						default: st_next.cke_prev = cke;
					endcase
					st_next.pwr = (|st_next.bank_open) ?
						ddr3_pwr_pkg::PWR_ACTIVE : ddr3_pwr_pkg::PWR_IDLE;
				end
			end
			default: st_next.pwr = ddr3_pwr_pkg::PWR_IDLE;
		endcase
		// Data windows open for the last beats of the countdown.
		st_next.read_strobe = st_next.burst_rd &&
			st_next.burst_cnt != 6'h00 && st_next.burst_cnt <= st_next.beats;
		st_next.write_window = !st_next.burst_rd &&
			st_next.burst_cnt != 6'h00 && st_next.burst_cnt <= st_next.beats;
		st_next.odt_active = odt && rtt_on(st_next.mr1, st_next.mr2) &&
			st_next.pwr != ddr3_pwr_pkg::PWR_SELF_REF;
		// DLL off needs CL 6 and CWL 6
		st_next.lat_error = st_next.mr1[`MR1_DLL_OFF_BIT] &&
			(cas_lat(st_next.mr0) != `DLL_OFF_CL ||
			cas_wr_lat(st_next.mr2) != `DLL_OFF_CWL);
	end

	// State register; reset loads only constants.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '{pwr: ddr3_pwr_pkg::PWR_IDLE, cke_prev: 1'b0,
				mr0: `MR_RESET_VAL, mr1: `MR_RESET_VAL, mr2: `MR_RESET_VAL,
				bank_open: 8'h00, burst_cnt: 6'h00, beats: 6'h00,
				burst_rd: 1'b0, burst_ap: 1'b0, burst_bank: 3'h0,
				read_strobe: 1'b0, write_window: 1'b0, odt_active: 1'b0,
				lat_error: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register.
	assign pwr_state = st_reg.pwr;
	assign bank_open = st_reg.bank_open;
	assign burst_busy = (st_reg.burst_cnt != 6'h00);
	assign read_strobe = st_reg.read_strobe;
	assign write_window = st_reg.write_window;
	assign odt_active = st_reg.odt_active;
	assign dll_disabled = st_reg.mr1[`MR1_DLL_OFF_BIT];
	assign lat_error = st_reg.lat_error;

	// Checks run on the one clock and stand down in reset.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_sr_entry_idle: assert property (
		st_reg.pwr == ddr3_pwr_pkg::PWR_IDLE && st_reg.cke_prev && !cke &&
		cmd == ddr3_pwr_pkg::CMD_REF && !busy
		|=> pwr_state == ddr3_pwr_pkg::PWR_SELF_REF)
		else $error("self refresh entry missed");
	a_sr_only_idle: assert property (
		$rose(pwr_state == ddr3_pwr_pkg::PWR_SELF_REF)
		|-> $past(pwr_state) == ddr3_pwr_pkg::PWR_IDLE)
		else $error("self refresh entered from non-idle");
	a_sr_exit_cke: assert property (
		pwr_state == ddr3_pwr_pkg::PWR_SELF_REF && cke
		|=> pwr_state == ddr3_pwr_pkg::PWR_IDLE)
		else $error("self refresh exit missed");
	a_pd_held_low: assert property (
		(pwr_state == ddr3_pwr_pkg::PWR_ACT_PD ||
		pwr_state == ddr3_pwr_pkg::PWR_PRE_PD) && !cke
		|=> $stable(pwr_state))
		else $error("power-down left with CKE low");
	// A bank whose auto-precharge is still pending counts as closed.
	a_pd_kind_banks: assert property (
		$rose(pwr_state == ddr3_pwr_pkg::PWR_PRE_PD) |->
		(bank_open & ~((burst_busy && st_reg.burst_ap) ?
		(8'h01 << st_reg.burst_bank) : 8'h00)) == 8'h00)
		else $error("precharge power-down with banks open");
	a_odt_off_sr: assert property (
		pwr_state == ddr3_pwr_pkg::PWR_SELF_REF |-> !odt_active)
		else $error("termination active in self refresh");
	a_nop_keeps: assert property (
		st_reg.cke_prev && cke && cmd == ddr3_pwr_pkg::CMD_NOP && !busy
		|=> $stable(bank_open) && $stable(st_reg.mr1))
		else $error("nop changed state");
	a_burst_uncut: assert property (
		burst_busy && st_reg.burst_cnt > 6'h01 |=> burst_busy)
		else $error("burst cut short");
	a_dll_bit_set: assert property (
		st_reg.pwr == ddr3_pwr_pkg::PWR_IDLE && st_reg.cke_prev && cke &&
		cmd == ddr3_pwr_pkg::CMD_MRS && ba == 3'h1
		|=> dll_disabled == $past(addr[0]))
		else $error("DLL bit not captured");
	a_read_beats: assert property (
		$rose(read_strobe) |-> read_strobe [*2])
		else $error("read strobe window too short");

	c_self_refresh: cover property (
		pwr_state == ddr3_pwr_pkg::PWR_SELF_REF ##1
		pwr_state == ddr3_pwr_pkg::PWR_IDLE);
	c_active_pd: cover property (
		pwr_state == ddr3_pwr_pkg::PWR_ACT_PD);
	c_dll_off_read: cover property (dll_disabled && $rose(read_strobe));
	c_write_burst: cover property ($rose(write_window));

endmodule

/* File: hw/ddr3_pwr_regs.svh */
/*
 * Constants for the DDR3 command and power-state core: mode register
 * field positions, reset values, latency bases and burst lengths.
 * Assumes it is included by bare name wherever the core needs it.
 */
`ifndef DDR3_PWR_REGS_SVH
`define DDR3_PWR_REGS_SVH

// Mode register reset value, all fields zero.
`define MR_RESET_VAL 14'h0000
// Burst length field of mode register 0, bits 1:0.
`define MR0_BL_MSB 1
`define MR0_BL_LSB 0
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_FIXED4 2'h2
// CAS latency field of mode register 0 and its base value.
`define MR0_CL_MSB 6
`define MR0_CL_LSB 4
`define CL_BASE 6'h04
// Mode register 1: DLL disable bit, additive latency, termination bits.
`define MR1_DLL_OFF_BIT 0
`define MR1_AL_MSB 4
`define MR1_AL_LSB 3
`define MR1_RTT_B0 2
`define MR1_RTT_B1 6
`define MR1_RTT_B2 9
// Mode register 2: CAS write latency field, its base, write termination.
`define MR2_CWL_MSB 5
`define MR2_CWL_LSB 3
`define CWL_BASE 6'h05
`define MR2_RTTWR_MSB 10
`define MR2_RTTWR_LSB 9
// Address bits that carry auto-precharge and burst chop.
`define ADDR_AP_BIT 10
`define ADDR_BC_BIT 12
// Data beats in clock cycles for a full and a chopped burst.
`define BEATS_BL8 6'h04
`define BEATS_BC4 6'h02
// Only latencies needed while the DLL is off.
`define DLL_OFF_CL 6'h06
`define DLL_OFF_CWL 6'h06

`endif

/* File: hw/ddr3_pwr_pkg.sv */
/*
 * Types for the DDR3 command and power-state core.
 * Assumes nothing of its surroundings; it is compiled before the core.
 */
package ddr3_pwr_pkg;

	// Power and bank state of the device.
	typedef enum logic [2:0] {
		PWR_IDLE,
		PWR_ACTIVE,
		PWR_ACT_PD,
		PWR_PRE_PD,
		PWR_SELF_REF
	} pwr_state_type;

	// Decoded command sampled at a rising edge.
	typedef enum logic [3:0] {
		CMD_DES,
		CMD_NOP,
		CMD_MRS,
		CMD_REF,
		CMD_PRE,
		CMD_ACT,
		CMD_WR,
		CMD_RD,
		CMD_ZQ
	} cmd_type;

	// Active-low command strobes sampled together.
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} cmd_pins_type;

	// Whole state of the core, registered as one word.
	typedef struct packed {
		pwr_state_type pwr;
		logic cke_prev;
		logic [13:0] mr0;
		logic [13:0] mr1;
		logic [13:0] mr2;
		logic [7:0] bank_open;
		logic [5:0] burst_cnt;
		logic [5:0] beats;
		logic burst_rd;
		logic burst_ap;
		logic [2:0] burst_bank;
		logic read_strobe;
		logic write_window;
		logic odt_active;
		logic lat_error;
	} core_state_type;

endpackage

/* File: dv/ctrl_model.sv */
/*
 * Behavioural memory controller driving the command, clock enable and
 * termination pins of the power-state core.
 * Assumes its tasks are called from the bench, one at a time.
 */
`timescale 1ns/1ps

module ctrl_model #(
	// Edges that clock enable is held after any change.
	parameter int CKE_MIN = 3,
	// Edges of deselect after leaving self refresh.
	parameter int EXIT_WAIT = 8
) (
	// Free running controller clock.
	input wire logic sys_clk,
	// Pins towards the device.
	output logic cke,
	output ddr3_pwr_pkg::cmd_pins_type cmd_pins,
	output logic [2:0] ba,
	output logic [13:0] addr,
	output logic odt
);

	// Power-up levels: clock enable low, device deselected.
	initial begin
		cke = 1'b0;
		cmd_pins = 4'hf;
		ba = 3'h0;
		addr = 14'h0000;
		odt = 1'b0;
	end

	// Deselect; the address lines show the inverse so a core that still
	// samples them while deselected is caught.
	// deselect between commands
	task automatic park();
		cmd_pins <= 4'hf;
		ba <= ~ba;
		addr <= ~addr;
	endtask

	// One command for exactly one edge, then deselect.
	task automatic send(input logic [3:0] p, input logic [2:0] b,
		input logic [13:0] a);
		@(posedge sys_clk);
		cmd_pins <= p;
		ba <= b;
		addr <= a;
		@(posedge sys_clk);
		park();
	endtask

	// Clock enable change with its command, then held steady.
	// hold clock enable
	task automatic set_cke(input logic k, input logic [3:0] p);
		@(posedge sys_clk);
		cke <= k;
		cmd_pins <= p;
		@(posedge sys_clk);
		park();
		repeat (CKE_MIN) @(posedge sys_clk);
	endtask

	// Termination request level.
	task automatic set_odt(input logic o);
		@(posedge sys_clk);
		odt <= o;
	endtask

	// Only deselect, clock enable high, until the exit time is over.
	// wait after exit
	task automatic exit_wait();
		repeat (EXIT_WAIT) @(posedge sys_clk);
	endtask

endmodule

/* File: dv/tb.sv */
/*
 * Self-checking bench for the power-state core: mode registers, bursts,
 * power-down, self refresh with a stopped clock, and reset.
 * Assumes the controller model drives every command pin.
 */
`timescale 1ns/1ps
`include "ddr3_pwr_regs.svh"

module tb;
	// Command strobe codes {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] P_MRS = 4'h0;
	localparam logic [3:0] P_REF = 4'h1;
	localparam logic [3:0] P_PRE = 4'h2;
	localparam logic [3:0] P_ACT = 4'h3;
	localparam logic [3:0] P_WR = 4'h4;
	localparam logic [3:0] P_RD = 4'h5;
	localparam logic [3:0] P_NOP = 4'h7;
	localparam logic [3:0] P_DES = 4'hf;
	// Edges from the command to the first beat, with zero additive
	// latency and CL, CWL of six; the DLL off takes one edge away.
	localparam int RL_ON = `DLL_OFF_CL;
	localparam int RL_OFF = `DLL_OFF_CL - 1;
	localparam int WL = `DLL_OFF_CWL;
	logic sys_clk;
	logic clk_run;
	logic dclk;
	logic reset_n;
	logic cke;
	ddr3_pwr_pkg::cmd_pins_type cmd_pins;
	logic [2:0] ba;
	logic [13:0] addr;
	logic odt;
	ddr3_pwr_pkg::pwr_state_type pwr_state;
	logic [7:0] bank_open;
	logic burst_busy;
	logic read_strobe;
	logic write_window;
	logic odt_active;
	logic dll_disabled;
	logic lat_error;
	int mismatches;
	int checked;
	int dly;
	int len;

	// The device clock can be stopped, as in self refresh.
	assign dclk = sys_clk & clk_run;

	// Free running 100 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	ctrl_model ctl (.sys_clk(sys_clk), .cke(cke), .cmd_pins(cmd_pins),
		.ba(ba), .addr(addr), .odt(odt));

	ddr3_pwr_core dut (.sys_clk(dclk), .reset_n(reset_n), .cke(cke),
		.cmd_pins(cmd_pins), .ba(ba), .addr(addr), .odt(odt),
		.pwr_state(pwr_state), .bank_open(bank_open),
		.burst_busy(burst_busy), .read_strobe(read_strobe),
		.write_window(write_window), .odt_active(odt_active),
		.dll_disabled(dll_disabled), .lat_error(lat_error));

	// Compare and count; unknowns never match.
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Power state compare.
	task automatic cs(input ddr3_pwr_pkg::pwr_state_type e);
		chk(14'(pwr_state), 14'(e));
	endtask

	// Let registered outputs land.
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// Edges from the command to the first beat, then beats; bounded.
	task automatic measure(input bit rd);
		dly = 0;
		len = 0;
		// The free clock is used: the gated one rises a delta later and
		// could still catch the command edge itself.
		do begin
			@(posedge sys_clk);
			#1;
			dly++;
		end while (dly < 40 && (rd ? read_strobe : write_window) !== 1'b1);
		chk(14'(burst_busy), 14'h0001);
		while (len < 40 && (rd ? read_strobe : write_window) === 1'b1) begin
			@(posedge sys_clk);
			#1;
			len++;
		end
	endtask

	// Counts, verdict and end of run.
	task automatic complete_run();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog: the tests take well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		complete_run();
	end

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		clk_run = 1'b1;
		mismatches = 0;
		checked = 0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		settle();
		cs(ddr3_pwr_pkg::PWR_IDLE);
		chk(14'({bank_open, dll_disabled, lat_error, odt_active}), 14'h0);
		$display("test reset done");
		// DLL off with CL and CWL of six; bank 3 is no register of ours.
		ctl.set_cke(1'b1, P_DES);
		ctl.send(P_MRS, 3'h0, 14'h0021);
		ctl.send(P_MRS, 3'h2, 14'h0008);
		ctl.send(P_MRS, 3'h1, 14'h0001);
		ctl.send(P_MRS, 3'h3, 14'h3ffe);
		settle();
		chk(14'(dll_disabled), 14'h0001);
		chk(14'(lat_error), 14'h0000);
		ctl.send(P_MRS, 3'h0, 14'h0001);
		settle();
		chk(14'(lat_error), 14'h0001);
		ctl.send(P_MRS, 3'h0, 14'h0021);
		settle();
		chk(14'(lat_error), 14'h0000);
		$display("test mode registers done");
		// Activate with termination requested; reads with the DLL off.
		ctl.set_odt(1'b1);
		ctl.send(P_ACT, 3'h1, 14'h0123);
		settle();
		cs(ddr3_pwr_pkg::PWR_ACTIVE);
		chk(14'(bank_open), 14'h0002);
		ctl.send(P_RD, 3'h1, 14'h1000);
		measure(1'b1);
		chk(14'(dly), 14'(RL_OFF));
		chk(14'(len), 14'(`BEATS_BL8));
		ctl.send(P_MRS, 3'h1, 14'h0000);
		settle();
		chk(14'(dll_disabled), 14'h0001);
		ctl.set_odt(1'b0);
		ctl.send(P_RD, 3'h1, 14'h0400);
		measure(1'b1);
		chk(14'(len), 14'(`BEATS_BC4));
		settle();
		chk(14'(bank_open), 14'h0000);
		cs(ddr3_pwr_pkg::PWR_IDLE);
		$display("test dll off bursts done");
		// DLL on again; nop and deselect during the burst.
		ctl.send(P_MRS, 3'h1, 14'h0000);
		ctl.send(P_ACT, 3'h1, 14'h0000);
		ctl.send(P_RD, 3'h1, 14'h1000);
		fork
			measure(1'b1);
			ctl.send(P_NOP, 3'h1, 14'h0000);
		join
		chk(14'(dly), 14'(RL_ON));
		chk(14'(len), 14'(`BEATS_BL8));
		ctl.send(P_WR, 3'h1, 14'h1000);
		measure(1'b0);
		chk(14'(dly), 14'(WL));
		chk(14'(len), 14'(`BEATS_BL8));
		$display("test dll on bursts done");
		// Active and precharge power-down.
		ctl.send(P_ACT, 3'h5, 14'h0000);
		ctl.set_cke(1'b0, P_NOP);
		settle();
		cs(ddr3_pwr_pkg::PWR_ACT_PD);
		ctl.send(P_ACT, 3'h2, 14'h0000);
		settle();
		chk(14'(bank_open), 14'h0022);
		ctl.set_cke(1'b1, P_DES);
		settle();
		cs(ddr3_pwr_pkg::PWR_ACTIVE);
		ctl.send(P_PRE, 3'h0, 14'h0400);
		ctl.set_cke(1'b0, P_DES);
		settle();
		chk(14'(bank_open), 14'h0000);
		cs(ddr3_pwr_pkg::PWR_PRE_PD);
		ctl.set_cke(1'b1, P_NOP);
		settle();
		cs(ddr3_pwr_pkg::PWR_IDLE);
		$display("test power down done");
		// Self refresh with termination enabled, the clock stopped inside it.
		ctl.send(P_MRS, 3'h1, 14'h0005);
		ctl.set_odt(1'b1);
		settle();
		chk(14'(odt_active), 14'h0001);
		ctl.set_cke(1'b0, P_REF);
		settle();
		cs(ddr3_pwr_pkg::PWR_SELF_REF);
		chk(14'(odt_active), 14'h0000);
		ctl.set_odt(1'b0);
		// clock held only in self refresh
		@(negedge sys_clk) clk_run <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// The clock runs steadily again before clock enable rises.
		@(negedge sys_clk) clk_run <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		cs(ddr3_pwr_pkg::PWR_SELF_REF);
		ctl.set_cke(1'b1, P_DES);
		#1;
		cs(ddr3_pwr_pkg::PWR_IDLE);
		ctl.exit_wait();
		$display("test self refresh done");
		// Reset in mid-run acts at once, without a clock edge.
		ctl.send(P_ACT, 3'h3, 14'h0000);
		settle();
		chk(14'(bank_open), 14'h0008);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		#3;
		cs(ddr3_pwr_pkg::PWR_IDLE);
		chk(14'({bank_open, dll_disabled}), 14'h0000);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		settle();
		cs(ddr3_pwr_pkg::PWR_IDLE);
		chk(14'({bank_open, lat_error}), 14'h0000);
		$display("test async reset done");
		complete_run();
	end

endmodule
